// ===== src/csif_pkg.sv
// Package: register map, field layout and link carrier types of the codec serial interface
package csif_pkg;

  localparam int          CSIF_DW       = 16;
  localparam int          CSIF_NBUF     = 4;
  localparam int          CSIF_AW       = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_FMT       = 8'h00;
  localparam logic [7:0]  OFS_CTRL      = 8'h04;
  localparam logic [7:0]  OFS_STAT      = 8'h08;
  localparam logic [7:0]  OFS_MASK      = 8'h0C;
  localparam logic [7:0]  OFS_RXBUF     = 8'h10;
  localparam logic [7:0]  OFS_TXBUF     = 8'h20;
  localparam logic [7:0]  OFS_BUF_SPAN  = 8'h10;

  // Frame and word format control fields
  localparam int          FMT_BLEN_HI   = 11;
  localparam int          FMT_BLEN_LO   = 10;
  localparam int          FMT_FLEN_HIGH = 8;
  localparam int          FMT_FLEN_LO_H = 7;
  localparam int          FMT_FLEN_LO_L = 5;
  localparam int          FMT_WS_HI     = 3;
  localparam int          FMT_WS_LO     = 0;
  localparam logic [15:0] FMT_WMASK     = 16'h0DEF;
  localparam logic [15:0] FMT_RESET     = 16'h0000;

  // Control, status and mask fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          ST_BLOCK_BIT  = 0;
  localparam int          ST_FRAME_BIT  = 1;
  localparam int          ST_W          = 2;
  localparam logic [1:0]  ST_RESET      = 2'h0;
  localparam logic [15:0] BUF_RESET     = 16'h0000;

  typedef enum logic [0:0] {
    CSIF_IDLE   = 1'b0,
    CSIF_ACTIVE = 1'b1
  } csif_state_t;

  typedef struct packed {
    logic bclk;
    logic fsync;
    logic sdi;
  } csif_link_in_t;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } csif_link_out_t;

endpackage

// ===== src/csif_shifter.sv
// Serial word shifter: parallel load left aligned, shift left, capture at bit 0
`timescale 1ns/1ps
module csif_shifter import csif_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // Control
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_data_in,
  input  wire logic         shift_in,
  input  wire logic         serial_in,
  // Word
  output logic      [W-1:0] word_out
);

  logic [W-1:0] word_q;
  logic [W-1:0] word_d;

  // Load has priority; a load on a shift edge starts the next word cleanly
  assign word_d = load_in  ? load_data_in :
                  shift_in ? {word_q[W-2:0], serial_in} : word_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  assign word_out = word_q;

endmodule

// ===== src/csif_top.sv
// Codec serial interface: format register, link shifter, word buffers, Wishbone slave
//////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Buffer length setting sits in bits 11:10, read/write, zero after reset.
// - Interrupt event after buffer length setting plus one words, one to four.
// - Frame length from bit 8 and bits 7:5; frame holds setting plus one words.
// - Each serial word is word size setting plus one bits long, one to sixteen.
//////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module csif_top import csif_pkg::*; (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // Wishbone slave
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [CSIF_AW-1:0]  wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  // Codec link pins
  input  wire csif_link_in_t       link_in,
  output csif_link_out_t           link_out,
  // Interrupt
  output logic                     irq_out
);

  ////////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0]          fmt_q;
  logic                 enable_q;
  logic [ST_W-1:0]      stat_q;
  logic [ST_W-1:0]      stat_d;
  logic [ST_W-1:0]      mask_q;
  logic [CSIF_DW-1:0]   rx_buf_q [CSIF_NBUF];
  logic [CSIF_DW-1:0]   tx_buf_q [CSIF_NBUF];
  logic [31:0]          rdata_q;
  logic                 ack_q;

  // Link side state
  csif_link_in_t        sync1_q;
  csif_link_in_t        sync2_q;
  logic                 bclk_prev_q;
  csif_state_t          state_q;
  logic [3:0]           bit_cnt_q;
  logic [3:0]           slot_q;
  logic [1:0]           buf_idx_q;
  logic                 sdo_q;

  ////////////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire  [1:0]           buffer_length_setting;
  wire  [3:0]           frame_length_setting;
  wire  [3:0]           word_size_setting;

  assign buffer_length_setting = fmt_q[FMT_BLEN_HI:FMT_BLEN_LO];
  assign frame_length_setting  = {fmt_q[FMT_FLEN_HIGH],
                                  fmt_q[FMT_FLEN_LO_H:FMT_FLEN_LO_L]};
  assign word_size_setting     = fmt_q[FMT_WS_HI:FMT_WS_LO];

  ////////////////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  wire                  wb_req;
  wire                  wb_wr;
  wire                  hit_fmt;
  wire                  hit_ctrl;
  wire                  hit_stat;
  wire                  hit_mask;
  wire                  hit_rx;
  wire                  hit_tx;
  wire  [1:0]           buf_sel;
  wire  [15:0]          wr_lanes;
  wire  [15:0]          fmt_merged;
  wire  [15:0]          tx_word_w;

  assign wb_req     = wb_cyc_in & wb_stb_in;
  // Writes land on the edge where the master samples ack
  assign wb_wr      = wb_req & wb_we_in & ack_q;
  assign hit_fmt    = (wb_adr_in == OFS_FMT);
  assign hit_ctrl   = (wb_adr_in == OFS_CTRL);
  assign hit_stat   = (wb_adr_in == OFS_STAT);
  assign hit_mask   = (wb_adr_in == OFS_MASK);
  assign hit_rx     = (wb_adr_in >= OFS_RXBUF) && (wb_adr_in < OFS_RXBUF + OFS_BUF_SPAN)
                      && (wb_adr_in[1:0] == 2'h0);
  assign hit_tx     = (wb_adr_in >= OFS_TXBUF) && (wb_adr_in < OFS_TXBUF + OFS_BUF_SPAN)
                      && (wb_adr_in[1:0] == 2'h0);
  assign buf_sel    = wb_adr_in[3:2];
  assign wr_lanes   = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign tx_word_w  = (wb_dat_in[15:0] & wr_lanes) | (tx_buf_q[buf_sel] & ~wr_lanes);
  // Only implemented fields take write data; the others stay zero
  assign fmt_merged = ((wb_dat_in[15:0] & wr_lanes) | (fmt_q & ~wr_lanes))
                      & FMT_WMASK;

  ////////////////////////////////////////////////////////////////////////////////////
  // Read data mux
  logic [31:0]          rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_fmt) begin
      rd_mux = {16'h0000, fmt_q & FMT_WMASK};
    end else if (hit_ctrl) begin
      rd_mux = {31'h0000_0000, enable_q};
    end else if (hit_stat) begin
      rd_mux = {30'h0000_0000, stat_q};
    end else if (hit_mask) begin
      rd_mux = {30'h0000_0000, mask_q};
    end else if (hit_rx) begin
      rd_mux = {16'h0000, rx_buf_q[buf_sel]};
    end else if (hit_tx) begin
      rd_mux = {16'h0000, tx_buf_q[buf_sel]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= wb_req & ~ack_q;
      rdata_q <= (wb_req & ~ack_q) ? rd_mux : rdata_q;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fmt_q    <= FMT_RESET;
      enable_q <= 1'b0;
      mask_q   <= ST_RESET;
    end else begin
      if (wb_wr && hit_fmt) begin
        fmt_q <= fmt_merged;
      end
      if (wb_wr && hit_ctrl && wb_sel_in[0]) begin
        enable_q <= wb_dat_in[CTRL_EN_BIT];
      end
      if (wb_wr && hit_mask && wb_sel_in[0]) begin
        mask_q <= wb_dat_in[ST_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < CSIF_NBUF; i++) begin
        tx_buf_q[i] <= BUF_RESET;
      end
    end else if (wb_wr && hit_tx) begin
      tx_buf_q[buf_sel] <= tx_word_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Link pin synchronisers; only the second stage is looked at
  wire                  bclk_rise;
  wire                  bclk_fall;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      bclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= link_in;
      sync2_q     <= sync1_q;
      bclk_prev_q <= sync2_q.bclk;
    end
  end

  assign bclk_rise = sync2_q.bclk & ~bclk_prev_q;
  assign bclk_fall = ~sync2_q.bclk & bclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  wire                  frame_start;
  wire                  bit_edge;
  wire                  word_done;
  wire                  frame_done;
  wire                  block_done;
  wire  [15:0]          shift_word;
  wire  [15:0]          rx_word;
  wire  [15:0]          tx_aligned;
  wire                  load_word;
  wire  [1:0]           next_idx;

  // Frame sync seen on a rising edge; data starts one bit clock later
  assign frame_start = enable_q & bclk_rise & sync2_q.fsync;
  assign bit_edge    = (state_q == CSIF_ACTIVE) & bclk_rise & ~frame_start;
  assign word_done   = bit_edge & (bit_cnt_q == word_size_setting);
  assign frame_done  = word_done & (slot_q == frame_length_setting);
  assign block_done  = word_done & (buf_idx_q == buffer_length_setting);
  assign rx_word     = {shift_word[14:0], sync2_q.sdi};
  assign next_idx    = block_done ? 2'h0 : buf_idx_q + 2'h1;
  // Word is sent MSB first, so it is aligned to the top of the shifter.
  // A frame start sends the current slot, since blocks may span frames.
  assign tx_aligned  = tx_buf_q[word_done ? next_idx : buf_idx_q]
                       << (4'hF - word_size_setting);
  assign load_word   = frame_start | (word_done & ~frame_done);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_q   <= CSIF_IDLE;
      bit_cnt_q <= 4'h0;
      slot_q    <= 4'h0;
    end else begin
      case (state_q)
        CSIF_IDLE: begin
          if (frame_start) begin
            state_q   <= CSIF_ACTIVE;
            bit_cnt_q <= 4'h0;
            slot_q    <= 4'h0;
          end
        end
        CSIF_ACTIVE: begin
          if (!enable_q) begin
            state_q <= CSIF_IDLE;
          end else if (frame_start) begin
            bit_cnt_q <= 4'h0;
            slot_q    <= 4'h0;
          end else if (frame_done) begin
            state_q <= CSIF_IDLE;
          end else if (word_done) begin
            bit_cnt_q <= 4'h0;
            slot_q    <= slot_q + 4'h1;
          end else if (bit_edge) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= CSIF_IDLE;
        end
      endcase
    end
  end

  // Buffer index survives frame boundaries so blocks may span frames
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      buf_idx_q <= 2'h0;
      for (int i = 0; i < CSIF_NBUF; i++) begin
        rx_buf_q[i] <= BUF_RESET;
      end
    end else if (!enable_q) begin
      buf_idx_q <= 2'h0;
    end else if (word_done) begin
      rx_buf_q[buf_idx_q] <= rx_word;
      buf_idx_q           <= next_idx;
    end
  end

  csif_shifter #(
    .W            (CSIF_DW)
  ) u_shifter (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .load_in      (load_word),
    .load_data_in (tx_aligned),
    .shift_in     (bit_edge),
    .serial_in    (sync2_q.sdi),
    .word_out     (shift_word)
  );

  // Output data changes on the falling bit clock edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sdo_q <= 1'b0;
    end else if (bclk_fall) begin
      sdo_q <= shift_word[CSIF_DW-1];
    end
  end

  assign link_out.sdo    = sdo_q;
  assign link_out.sdo_oe = (state_q == CSIF_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////////////
  // Interrupt status: a new event wins over a write-one clear in the same cycle
  wire  [ST_W-1:0]      st_event;
  wire  [ST_W-1:0]      st_clear;

  assign st_event = {frame_done, block_done};
  assign st_clear = (wb_wr && hit_stat && wb_sel_in[0]) ? wb_dat_in[ST_W-1:0] : 2'h0;
  assign stat_d   = (stat_q & ~st_clear) | st_event;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stat_q <= ST_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign irq_out = |(stat_q & mask_q);

endmodule

// ===== test/csif_top_assertions.sv
// Checker of bus, interrupt and link relations at the top ports
`timescale 1ns/1ps
module csif_top_checker import csif_pkg::*; (
  // Clock and reset
  input wire logic               core_clk_in,
  input wire logic               rst_in,
  // Wishbone
  input wire logic               wb_cyc_in,
  input wire logic               wb_stb_in,
  input wire logic               wb_we_in,
  input wire logic [CSIF_AW-1:0] wb_adr_in,
  input wire logic [31:0]        wb_dat_in,
  input wire logic [31:0]        wb_dat_out,
  input wire logic               wb_ack_out,
  // Link and interrupt
  input wire csif_link_in_t      link_in,
  input wire csif_link_out_t     link_out,
  input wire logic               irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] fmt_q;
  wire         req = wb_cyc_in && wb_stb_in;
  wire         fmt_ack = wb_ack_out && wb_adr_in == OFS_FMT;
  wire         fmt_rd = fmt_ack && !wb_we_in;
  // Shadow assumes both byte lanes enabled on format writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in)
      fmt_q <= 16'h0000;
    else if (fmt_ack && wb_we_in)
      fmt_q <= wb_dat_in[15:0] & 16'h0DEF;
  end
  ////////////////////////////////////////
  a_ack_in_one: assert property (req && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_fmt_readback: assert property (
    fmt_rd |-> wb_dat_out == {16'h0000, fmt_q})
    else $error("format readback wrong");
  a_dat_hold: assert property (!req |=> $stable(wb_dat_out))
    else $error("read data changed without request");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(wb_ack_out && wb_we_in))
    else $error("irq dropped without a write");
  a_irq_rise: assert property (
    $rose(irq_out) |-> $past(wb_ack_out && wb_we_in) || $past(link_out.sdo_oe)
      || $past(link_out.sdo_oe, 2))
    else $error("irq rose without write or frame");
  a_oe_start: assert property ($rose(link_out.sdo_oe) |-> $past(link_in.fsync, 3))
    else $error("frame started without frame sync");
  a_sdo_low_clk: assert property (
    $changed(link_out.sdo) && link_out.sdo_oe |-> !link_in.bclk)
    else $error("serial output changed while bit clock high");
  c_fmt_read: cover property (fmt_rd);
  c_irq_rise: cover property ($rose(irq_out));
  c_frame_end: cover property ($fell(link_out.sdo_oe));
endmodule

bind csif_top csif_top_checker u_csif_top_checker (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .link_in(link_in), .link_out(link_out), .irq_out(irq_out));

// ===== test/csif_codec_model.sv
// Codec model: bit clock, frame sync and serial data, samples serial output
`timescale 1ns/1ps
module csif_codec_model (
  // Link pins
  output logic      bclk_out,
  output logic      fsync_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  logic [15:0] tx_word [16];
  logic [15:0] rx_word [16];
  initial begin
    bclk_out = 1'b0;
    fsync_out = 1'b0;
    sdi_out = 1'b0;
  end
  // Bit clock stands still between frames; idle data inverts so stale bits never match
  task automatic run_frame(input int nw, input int nb);
    // Keep every pin change clear of the core clock edge
    #3;
    fsync_out = 1'b1;
    sdi_out = ~sdi_out;
    #80 bclk_out = 1'b1;
    #80 bclk_out = 1'b0;
    fsync_out = 1'b0;
    for (int w = 0; w < nw; w++) begin
      rx_word[w] = 16'h0000;
      for (int b = nb - 1; b >= 0; b--) begin
        sdi_out = tx_word[w][b];
        #80 bclk_out = 1'b1;
        rx_word[w][b] = sdo_in;
        #80 bclk_out = 1'b0;
      end
    end
    sdi_out = ~sdi_out;
  endtask
endmodule

// ===== test/test_csif_top.sv
// Bench: format register access, frames over several formats, interrupts
`timescale 1ns/1ps
module test_csif_top import csif_pkg::*;;
  logic           clk, ack, irq, bclk, fsync, sdi;
  logic           rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [7:0]     adr = 8'h00;
  logic [31:0]    wdat = 32'h0, rdat, rd;
  logic [15:0]    exp_rx [4];
  logic [15:0]    exp_tx [16];
  logic [3:0]     seen;
  csif_link_in_t  lin;
  csif_link_out_t lout;
  int             n_mismatch = 0, n_checks = 0;

  assign lin = {bclk, fsync, sdi};
  csif_top u_csif_top (
    .core_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .link_in(lin), .link_out(lout), .irq_out(irq));
  csif_codec_model u_csif_codec_model (
    .bclk_out(bclk), .fsync_out(fsync), .sdi_out(sdi), .sdo_in(lout.sdo));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk("ack wait", 32'h2, 32'(n));
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk);
    chk("ack drop", 32'h0, {31'h0, ack});
  endtask
  task automatic t_regs();
    wb(1'b0, OFS_FMT, 32'h0);
    chk("fmt reset", 32'h0000_0000, rd);
    chk("irq reset", 32'h0, {31'h0, irq});
    wb(1'b1, OFS_FMT, 32'h0000_F210);
    wb(1'b0, OFS_FMT, 32'h0);
    chk("fmt unused", 32'h0000_0000, rd);
    wb(1'b1, OFS_FMT, 32'hFFFF_FFFF);
    wb(1'b0, OFS_FMT, 32'h0);
    chk("fmt ones", 32'h0000_0DEF, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0000_0000, rd);
  endtask
  task automatic t_frame(input logic [3:0] ws, input logic [3:0] fl, input logic [1:0] bl,
                         input int nfr);
    int          idx;
    logic        wrap;
    logic [15:0] m;
    idx = 0;
    seen = 4'h0;
    m = 16'hFFFF >> (4'hF - ws);
    wb(1'b1, OFS_CTRL, 32'h0);
    wb(1'b1, OFS_FMT, {20'h0, bl, 1'b0, fl[3], fl[2:0], 1'b0, ws});
    for (int i = 0; i < 4; i++)
      wb(1'b1, OFS_TXBUF + 8'(4 * i), {16'h0, {4{4'(i + 5)}}});
    wb(1'b1, OFS_MASK, 32'h2);
    wb(1'b1, OFS_STAT, 32'h3);
    wb(1'b1, OFS_CTRL, 32'h1);
    for (int f = 0; f < nfr; f++) begin
      wrap = 1'b0;
      for (int w = 0; w <= fl; w++) begin
        u_csif_codec_model.tx_word[w] = 16'h5A3C ^ {4{4'(w + 3 * f)}};
        exp_rx[idx] = u_csif_codec_model.tx_word[w] & m;
        exp_tx[w] = {4{4'(idx + 5)}};
        seen[idx] = 1'b1;
        wrap |= (idx == bl);
        idx = (idx == bl) ? 0 : idx + 1;
      end
      u_csif_codec_model.run_frame(fl + 1, ws + 1);
      @(posedge clk);
      for (int n = 0; n < 60 && irq !== 1'b1; n++)
        @(posedge clk);
      chk("frame irq", 32'h1, {31'h0, irq});
      wb(1'b0, OFS_STAT, 32'h0);
      chk("status", {30'h0, 1'b1, wrap}, rd);
      for (int i = 0; i < 4; i++)
        if (seen[i]) begin
          wb(1'b0, OFS_RXBUF + 8'(4 * i), 32'h0);
          chk("rx word", {16'h0, exp_rx[i]}, rd);
        end
      // Short words carry the low bits of their buffer slot, MSB first
      for (int w = 0; w <= fl; w++)
        chk("tx word", {16'h0, exp_tx[w] & m}, {16'h0, u_csif_codec_model.rx_word[w]});
      wb(1'b1, OFS_MASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, OFS_MASK, 32'h3);
      wb(1'b1, OFS_STAT, 32'h2);
      chk("irq block", {31'h0, wrap}, {31'h0, irq});
      wb(1'b1, OFS_STAT, 32'h1);
      chk("irq clear", 32'h0, {31'h0, irq});
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_frame(4'h3, 4'h0, 2'h0, 2);
    t_frame(4'hF, 4'h1, 2'h3, 2);
    t_frame(4'h4, 4'h2, 2'h1, 1);
    t_frame(4'h7, 4'hF, 2'h2, 1);
    summarize();
  end
endmodule
